// file: src/port_b_mux_defines.vh
// bit positions, reset values and divider defaults of the port b override logic
`ifndef PORT_B_MUX_DEFINES_VH
`define PORT_B_MUX_DEFINES_VH

// pin positions of the shared functions
`define PB_SCK_BIT 3'd7
`define PB_MISO_BIT 3'd6
`define PB_MOSI_BIT 3'd5
`define PB_SS_BIT 3'd4
`define PB_OCA_BIT 3'd3
`define PB_EXTERNAL_IRQ_TWO_BIT 3'd2
`define PB_DIVIDED_CLOCK_OUTPUT_BIT 3'd1
`define PB_XCK_BIT 3'd0

// number of pins in the port
`define PB_WIDTH 8

// reset values of the registered outputs
`define PB_PAD_OUT_RST 8'h00
`define PB_PAD_OE_RST 8'h00
`define PB_PULLUP_RST 8'h00
`define PB_INPUT_EN_RST 8'h00
`define PB_PC_SRC_RST 8'h00
`define PB_DIN_RST 1'b0
// slave select idles high so the spi stays inactive through reset
`define PB_SS_RST 1'b1

// clock output divider: toggle every half period of this many cycles
`define PB_CLK_HALF_DEFAULT 8'h01
`define PB_CLK_CNT_W 8

`endif

// file: src/clock_out_driver.v
// divided clock output driver for pin 1, alive through device reset
`include "port_b_mux_defines.vh"

module clock_out_driver #(
   parameter CNT_W = `PB_CLK_CNT_W,
   parameter [CNT_W-1:0] HALF_PERIOD = `PB_CLK_HALF_DEFAULT
) (
   // clock and power-on reset only, device reset does not reach here
   input wire clk,
   input wire por_b,
   // fuse strap and plain port path for the pin
   input wire clock_output_fuse,
   input wire plain_out,
   input wire plain_oe,
   // pad drive
   output reg pin_out_reg,
   output reg pin_oe_reg,
   output reg divided_clock_output
);

   reg [CNT_W-1:0] div_cnt_reg;
   reg [CNT_W-1:0] div_cnt_next;
   reg div_clk_next;

   always @* begin
      div_cnt_next = div_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      div_clk_next = divided_clock_output;
      if (div_cnt_next >= HALF_PERIOD) begin
         div_cnt_next = {CNT_W{1'b0}};
         div_clk_next = ~divided_clock_output;
      end
   end

   // only power-on clears these, so the clock keeps running under rst_b
   always @(posedge clk or negedge por_b) begin
      if (!por_b) begin
         div_cnt_reg <= {CNT_W{1'b0}};
         divided_clock_output <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         divided_clock_output <= div_clk_next;
         if (clock_output_fuse) begin
            pin_out_reg <= div_clk_next;
            pin_oe_reg <= 1'b1;
         end else begin
            pin_out_reg <= plain_out;
            pin_oe_reg <= plain_oe;
         end
      end
   end

endmodule // clock_out_driver

// file: src/port_b_alt_function_mux.v
// override logic for the eight pins of port b and their peripheral taps
`include "port_b_mux_defines.vh"

module port_b_alt_function_mux #(
   parameter W = `PB_WIDTH,
   parameter CNT_W = `PB_CLK_CNT_W,
   parameter [CNT_W-1:0] CLK_HALF_PERIOD = `PB_CLK_HALF_DEFAULT
) (
   // clock and resets
   input wire clk,
   input wire rst_b,
   input wire por_b,
   // port register bits and global controls
   input wire [W-1:0] direction_bits,
   input wire [W-1:0] port_out_bits,
   input wire global_pullup_disable,
   input wire sleep_mode,
   // pad level as sampled
   input wire [W-1:0] pad_in,
   // spi controls and outputs
   input wire serial_periph_enable,
   input wire serial_master_select,
   input wire spi_sck_out,
   input wire spi_master_out,
   input wire spi_slave_out,
   // timer 0 compare outputs
   input wire timer0_compare_a_enable,
   input wire timer0_compare_a_out,
   input wire timer0_compare_b_enable,
   input wire timer0_compare_b_out,
   // clock output strap
   input wire clock_output_fuse,
   // usart0 synchronous clock
   input wire usart0_sync_mode,
   input wire usart0_clock_out,
   // interrupt enables
   input wire [W-1:0] pin_change_mask,
   input wire pin_change_group1_enable,
   input wire external_irq_two_enable,
   // pad drive
   output wire [W-1:0] pad_out,
   output wire [W-1:0] pad_oe,
   output reg [W-1:0] pad_pullup,
   output reg [W-1:0] pad_input_en,
   // spi taps
   output reg spi_sck_in,
   output reg spi_master_in,
   output reg spi_slave_in,
   output reg spi_select_in,
   // interrupt, counter and clock taps
   output reg [W-1:0] pin_change_src,
   output reg external_irq_two,
   output reg timer0_count_input,
   output reg timer1_count_input,
   output reg usart0_sync_clock,
   // comparator taps and divided clock
   output reg comparator_plus_input,
   output reg comparator_minus_input,
   output wire divided_clock_output
);

   // generic override: when enabled the override value wins
   function pick;
      input en;
      input ov;
      input dflt;
      begin
         pick = en ? ov : dflt;
      end
   endfunction

   reg [W-1:0] pullup_override_enable;
   reg [W-1:0] pullup_override_value;
   reg [W-1:0] direction_override_enable;
   reg [W-1:0] direction_override_value;
   reg [W-1:0] pin_value_override_enable;
   reg [W-1:0] pin_value_override_value;
   reg [W-1:0] input_enable_override_enable;
   reg [W-1:0] input_enable_override_value;
   reg [W-1:0] oe_next;
   reg [W-1:0] out_next;
   reg [W-1:0] pullup_next;
   reg [W-1:0] input_en_next;
   reg [W-1:0] din;
   reg [W-1:0] pad_out_reg;
   reg [W-1:0] pad_oe_reg;
   wire spi_slave;
   wire spi_master;
   wire pin1_out;
   wire pin1_oe;
   integer i;
   // separate loop index so the two combinational processes share no variable
   integer j;

   assign spi_slave = serial_periph_enable & ~serial_master_select;
   assign spi_master = serial_periph_enable & serial_master_select;

   // override enables zero unless a function claims the pin, pull-up and input enable values set on every pin
   always @* begin
      pullup_override_enable = {W{1'b0}};
      pullup_override_value = {W{1'b0}};
      direction_override_enable = {W{1'b0}};
      direction_override_value = {W{1'b0}};
      pin_value_override_enable = {W{1'b0}};
      pin_value_override_value = {W{1'b0}};
      input_enable_override_enable = {W{1'b0}};
      input_enable_override_value = {W{1'b0}};
      // pin 7: spi clock
      direction_override_enable[`PB_SCK_BIT] = spi_slave;
      pullup_override_enable[`PB_SCK_BIT] = spi_slave;
      pin_value_override_enable[`PB_SCK_BIT] = spi_master;
      pin_value_override_value[`PB_SCK_BIT] = spi_sck_out;
      // pin 6: master receive, slave transmit
      direction_override_enable[`PB_MISO_BIT] = spi_master;
      pullup_override_enable[`PB_MISO_BIT] = spi_master;
      pin_value_override_enable[`PB_MISO_BIT] = spi_slave;
      pin_value_override_value[`PB_MISO_BIT] = spi_slave_out;
      // pin 5: master transmit, slave receive
      direction_override_enable[`PB_MOSI_BIT] = spi_slave;
      pullup_override_enable[`PB_MOSI_BIT] = spi_slave;
      pin_value_override_enable[`PB_MOSI_BIT] = spi_master;
      pin_value_override_value[`PB_MOSI_BIT] = spi_master_out;
      // pin 4: slave select, compare b
      direction_override_enable[`PB_SS_BIT] = spi_slave;
      pullup_override_enable[`PB_SS_BIT] = spi_slave;
      pin_value_override_enable[`PB_SS_BIT] = timer0_compare_b_enable;
      pin_value_override_value[`PB_SS_BIT] = timer0_compare_b_out;
      // pin 3: compare a
      pin_value_override_enable[`PB_OCA_BIT] = timer0_compare_a_enable;
      pin_value_override_value[`PB_OCA_BIT] = timer0_compare_a_out;
      // pin 1: clock output strap forces the driver on
      direction_override_enable[`PB_DIVIDED_CLOCK_OUTPUT_BIT] = clock_output_fuse;
      direction_override_value[`PB_DIVIDED_CLOCK_OUTPUT_BIT] = clock_output_fuse;
      // pin 0: usart0 clock out only in synchronous mode
      pin_value_override_enable[`PB_XCK_BIT] = usart0_sync_mode;
      pin_value_override_value[`PB_XCK_BIT] = usart0_clock_out;
      // forced spi inputs keep the port output bit as pull-up control
      for (i = 0; i < W; i = i + 1) begin
         pullup_override_value[i] = port_out_bits[i] & ~global_pullup_disable;
         input_enable_override_enable[i] = pin_change_mask[i] & pin_change_group1_enable;
         input_enable_override_value[i] = 1'b1;
      end
      input_enable_override_enable[`PB_EXTERNAL_IRQ_TWO_BIT] = input_enable_override_enable[`PB_EXTERNAL_IRQ_TWO_BIT] | external_irq_two_enable;
   end

   // resolved pad controls for the next cycle
   always @* begin
      oe_next = {W{1'b0}};
      out_next = {W{1'b0}};
      pullup_next = {W{1'b0}};
      input_en_next = {W{1'b0}};
      din = {W{1'b0}};
      for (j = 0; j < W; j = j + 1) begin
         oe_next[j] = pick(direction_override_enable[j], direction_override_value[j], direction_bits[j]);
         // value only reaches the pad while the driver is on
         out_next[j] = oe_next[j] & pick(pin_value_override_enable[j], pin_value_override_value[j], port_out_bits[j]);
         pullup_next[j] = pick(pullup_override_enable[j], pullup_override_value[j],
            ~direction_bits[j] & port_out_bits[j] & ~global_pullup_disable);
         // an enabled driver never needs a pull-up
         pullup_next[j] = pullup_next[j] & ~oe_next[j];
         input_en_next[j] = pick(input_enable_override_enable[j], input_enable_override_value[j], ~sleep_mode);
         din[j] = pad_in[j] & input_en_next[j];
      end
   end

   // pin 1 lives in a domain that device reset does not touch
   clock_out_driver #(
      .CNT_W(CNT_W),
      .HALF_PERIOD(CLK_HALF_PERIOD)
   ) u_clock_out (
      .clk(clk),
      .por_b(por_b),
      .clock_output_fuse(clock_output_fuse),
      .plain_out(out_next[`PB_DIVIDED_CLOCK_OUTPUT_BIT]),
      .plain_oe(oe_next[`PB_DIVIDED_CLOCK_OUTPUT_BIT]),
      .pin_out_reg(pin1_out),
      .pin_oe_reg(pin1_oe),
      .divided_clock_output(divided_clock_output)
   );

   assign pad_out = {pad_out_reg[W-1:2], pin1_out, pad_out_reg[0]};
   assign pad_oe = {pad_oe_reg[W-1:2], pin1_oe, pad_oe_reg[0]};

   // pad registers, one cycle behind the controls
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pad_out_reg <= `PB_PAD_OUT_RST;
         pad_oe_reg <= `PB_PAD_OE_RST;
         pad_pullup <= `PB_PULLUP_RST;
         pad_input_en <= `PB_INPUT_EN_RST;
      end else begin
         pad_out_reg <= out_next;
         pad_oe_reg <= oe_next;
         pad_pullup <= pullup_next;
         pad_input_en <= input_en_next;
      end
   end

   // peripheral taps taken from the gated digital inputs, comparator taps from the raw pad
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         spi_sck_in <= `PB_DIN_RST;
         spi_master_in <= `PB_DIN_RST;
         spi_slave_in <= `PB_DIN_RST;
         spi_select_in <= `PB_SS_RST;
         pin_change_src <= `PB_PC_SRC_RST;
         external_irq_two <= `PB_DIN_RST;
         timer0_count_input <= `PB_DIN_RST;
         timer1_count_input <= `PB_DIN_RST;
         usart0_sync_clock <= `PB_DIN_RST;
         comparator_plus_input <= `PB_DIN_RST;
         comparator_minus_input <= `PB_DIN_RST;
      end else begin
         spi_sck_in <= din[`PB_SCK_BIT];
         spi_master_in <= din[`PB_MISO_BIT];
         spi_slave_in <= din[`PB_MOSI_BIT];
         // low level here activates a slave spi
         spi_select_in <= din[`PB_SS_BIT];
         pin_change_src <= din;
         external_irq_two <= din[`PB_EXTERNAL_IRQ_TWO_BIT];
         timer1_count_input <= din[`PB_DIVIDED_CLOCK_OUTPUT_BIT];
         timer0_count_input <= din[`PB_XCK_BIT];
         // external clock is an input only in synchronous mode with direction clear
         usart0_sync_clock <= usart0_sync_mode & ~direction_bits[`PB_XCK_BIT]
            & din[`PB_XCK_BIT];
         // digital stand-in for the analog taps: raw pad, no enable gating
         comparator_plus_input <= pad_in[`PB_EXTERNAL_IRQ_TWO_BIT];
         comparator_minus_input <= pad_in[`PB_OCA_BIT];
      end
   end

endmodule // port_b_alt_function_mux

// file: tb/port_b_mux_checker.sv
// concurrent checks on the port b override logic pins
module port_b_mux_checker #(
   parameter int CLK_HALF_PERIOD = 1
) (
   // clock and resets
   input wire clk,
   input wire rst_b,
   input wire por_b,
   // controls and pad level
   input wire [7:0] direction_bits,
   input wire [7:0] port_out_bits,
   input wire global_pullup_disable,
   input wire sleep_mode,
   input wire [7:0] pad_in,
   input wire serial_periph_enable,
   input wire serial_master_select,
   input wire timer0_compare_a_enable,
   input wire timer0_compare_a_out,
   input wire timer0_compare_b_enable,
   input wire timer0_compare_b_out,
   input wire clock_output_fuse,
   input wire [7:0] pin_change_mask,
   input wire pin_change_group1_enable,
   input wire external_irq_two_enable,
   // observed outputs
   input wire [7:0] pad_out,
   input wire [7:0] pad_oe,
   input wire [7:0] pad_pullup,
   input wire [7:0] pad_input_en,
   input wire external_irq_two,
   input wire comparator_plus_input,
   input wire comparator_minus_input,
   input wire divided_clock_output
);
   wire slv = serial_periph_enable & ~serial_master_select;
   wire mst = serial_periph_enable & serial_master_select;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // outputs lag inputs by one edge, so each antecedent also needs reset gone a cycle (por_b for the pin 1 checks, two cycles for the toggle)
   slave_sck_a: assert property ($past(rst_b && slv) |-> !pad_oe[7] && !pad_out[7])
      else $error("clock pin driven as slave");
   master_miso_a: assert property ($past(rst_b && mst) |-> !pad_oe[6])
      else $error("receive pin driven as master");
   slave_inputs_a: assert property ($past(rst_b && slv) |-> pad_oe[5:4] == 2'b00)
      else $error("slave input pins driven");
   forced_pullup_a: assert property ($past(rst_b && slv) |->
      pad_pullup[7] == $past(port_out_bits[7] & ~global_pullup_disable))
      else $error("forced pin pull-up wrong");
   compare_b_a: assert property ($past(rst_b && timer0_compare_b_enable && direction_bits[4] && !slv)
      |-> pad_oe[4] && pad_out[4] == $past(timer0_compare_b_out))
      else $error("compare b not on pin 4");
   compare_a_a: assert property ($past(rst_b && timer0_compare_a_enable && direction_bits[3])
      |-> pad_oe[3] && pad_out[3] == $past(timer0_compare_a_out))
      else $error("compare a not on pin 3");
   plain_pin_a: assert property ($past(rst_b && !timer0_compare_a_enable) |-> pad_oe[3] ==
      $past(direction_bits[3]) && pad_out[3] == $past(direction_bits[3] & port_out_bits[3]))
      else $error("plain pin 3 wrong");
   clock_drive_a: assert property (disable iff (!por_b)
      $past(por_b) && $past(clock_output_fuse) |-> pad_oe[1])
      else $error("clock pin not driven");
   clock_toggle_a: assert property (disable iff (!por_b)
      CLK_HALF_PERIOD == 1 && $past(por_b, 2) |-> $changed(divided_clock_output))
      else $error("divided clock stalled");
   change_enable_a: assert property ($past(rst_b && pin_change_group1_enable && pin_change_mask[7])
      |-> pad_input_en[7])
      else $error("pin change input disabled");
   irq_two_a: assert property ($past(rst_b && external_irq_two_enable) |->
      pad_input_en[2] && external_irq_two == $past(pad_in[2]))
      else $error("interrupt two tap wrong");
   comparator_a: assert property ($past(rst_b) |->
      {comparator_minus_input, comparator_plus_input} == $past(pad_in[3:2]))
      else $error("comparator taps wrong");
   sleep_off_a: assert property ($past(rst_b && sleep_mode && !pin_change_group1_enable &&
      !external_irq_two_enable) |-> pad_input_en == 8'h00)
      else $error("inputs enabled in sleep");
endmodule // port_b_mux_checker
bind port_b_alt_function_mux port_b_mux_checker #(.CLK_HALF_PERIOD(CLK_HALF_PERIOD)) port_b_mux_checker_i (.*);

// file: tb/port_b_pad_peer.sv
// pad-side model resolving each pin between the mux drive and the outside party
module port_b_pad_peer (
   // clock
   input wire clk,
   // mux pad drive
   input wire [7:0] pad_out,
   input wire [7:0] pad_oe,
   input wire [7:0] pad_pullup,
   // outside party drive
   input wire [7:0] ext,
   input wire [7:0] ext_oe,
   // sampled pad level
   output logic [7:0] pad_in = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // a floating pin without pull-up shows the inverse of its last level so no stale value passes
   always @(negedge clk) begin
      for (int n = 0; n < 8; n++) begin
         pad_in[n] <= pad_oe[n] ? pad_out[n] : ext_oe[n] ? ext[n] : pad_pullup[n] | ~pad_in[n];
      end
   end
endmodule // port_b_pad_peer

// file: tb/tb.sv
// self-checking bench for the port b override logic
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, por_b = 0, global_pullup_disable = 0, sleep_mode = 0;
   logic serial_periph_enable = 0, serial_master_select = 0, spi_sck_out = 0;
   logic spi_master_out = 0, spi_slave_out = 0, clock_output_fuse = 1;
   logic timer0_compare_a_enable = 0, timer0_compare_a_out = 0;
   logic timer0_compare_b_enable = 0, timer0_compare_b_out = 0;
   logic usart0_sync_mode = 0, usart0_clock_out = 0, pin_change_group1_enable = 0;
   logic external_irq_two_enable = 0, d;
   logic [7:0] direction_bits = 0, port_out_bits = 0, pin_change_mask = 0, ext = 0, ext_oe = 8'hFF;
   wire [7:0] pad_in, pad_out, pad_oe, pad_pullup, pad_input_en, pin_change_src;
   wire spi_sck_in, spi_master_in, spi_slave_in, spi_select_in, external_irq_two;
   wire timer0_count_input, timer1_count_input, usart0_sync_clock;
   wire comparator_plus_input, comparator_minus_input, divided_clock_output;
   int miscompares = 0;
   int checked = 0;
   always #5 clk = ~clk;
   port_b_alt_function_mux #(.CLK_HALF_PERIOD(8'h01)) port_b_alt_function_mux_i (.*);
   port_b_pad_peer port_b_pad_peer_i (.*);
   task go(input int n);
      repeat (n) @(negedge clk);
   endtask
   task end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // whole run is under a hundred cycles
   initial begin
      #5000;
      miscompares++;
      end_of_test;
   end
   initial begin
      go(3);
      por_b = 1;
      go(3);
      `CHK("reset oe", 8'h02, pad_oe)
      `CHK("reset pullup", 8'h00, pad_pullup)
      `CHK("reset select", 1'b1, spi_select_in)
      d = divided_clock_output;
      go(1);
      `CHK("clock in reset", ~d, divided_clock_output)
      $display("reset test done");
      rst_b = 1;
      clock_output_fuse = 0;
      serial_periph_enable = 1;
      direction_bits = 8'hFF;
      port_out_bits = 8'hFF;
      spi_slave_out = 1;
      ext = 8'hA0;
      go(3);
      `CHK("slave oe", 8'h4F, pad_oe)
      `CHK("slave out", 8'h4F, pad_out)
      `CHK("slave pullup", 8'hB0, pad_pullup)
      `CHK("slave rx", 1'b1, spi_slave_in)
      `CHK("slave clock", 1'b1, spi_sck_in)
      `CHK("slave select", 1'b0, spi_select_in)
      serial_master_select = 1;
      spi_sck_out = 1;
      global_pullup_disable = 1;
      ext = 8'h40;
      go(3);
      `CHK("master oe", 8'hBF, pad_oe)
      `CHK("master out", 8'h9F, pad_out)
      `CHK("master pullup", 8'h00, pad_pullup)
      `CHK("master rx", 1'b1, spi_master_in)
      $display("spi test done");
      serial_periph_enable = 0;
      serial_master_select = 0;
      global_pullup_disable = 0;
      direction_bits = 8'h18;
      port_out_bits = 8'h10;
      timer0_compare_a_enable = 1;
      timer0_compare_a_out = 1;
      timer0_compare_b_enable = 1;
      ext = 8'h00;
      go(2);
      `CHK("compare oe", 8'h18, pad_oe)
      `CHK("compare out", 8'h08, pad_out)
      direction_bits = 8'h00;
      go(2);
      `CHK("compare off oe", 8'h00, pad_oe)
      `CHK("compare off out", 8'h00, pad_out)
      `CHK("plain pullup", 8'h10, pad_pullup)
      $display("compare test done");
      timer0_compare_a_enable = 0;
      timer0_compare_b_enable = 0;
      port_out_bits = 8'h00;
      usart0_sync_mode = 1;
      usart0_clock_out = 1;
      direction_bits = 8'h01;
      go(2);
      `CHK("usart out", 8'h01, pad_out)
      `CHK("usart in off", 1'b0, usart0_sync_clock)
      direction_bits = 8'h00;
      ext = 8'h03;
      go(3);
      `CHK("usart in", 1'b1, usart0_sync_clock)
      `CHK("count zero", 1'b1, timer0_count_input)
      `CHK("count one", 1'b1, timer1_count_input)
      usart0_sync_mode = 0;
      direction_bits = 8'h01;
      go(3);
      `CHK("async out", 8'h00, pad_out)
      `CHK("async in", 1'b0, usart0_sync_clock)
      clock_output_fuse = 1;
      go(3);
      `CHK("fuse oe", 8'h03, pad_oe)
      d = pad_out[1];
      go(1);
      `CHK("fuse clock", ~d, pad_out[1])
      $display("usart and clock test done");
      clock_output_fuse = 0;
      direction_bits = 8'h00;
      sleep_mode = 1;
      ext = 8'h0C;
      go(3);
      `CHK("sleep input", 8'h00, pad_input_en)
      `CHK("comparator", 2'b11, {comparator_minus_input, comparator_plus_input})
      `CHK("sleep irq", 1'b0, external_irq_two)
      external_irq_two_enable = 1;
      pin_change_mask = 8'h80;
      pin_change_group1_enable = 1;
      ext = 8'h8C;
      go(3);
      `CHK("wake input", 8'h84, pad_input_en)
      `CHK("irq two", 1'b1, external_irq_two)
      `CHK("change src", 1'b1, pin_change_src[7])
      sleep_mode = 0;
      pin_change_group1_enable = 0;
      external_irq_two_enable = 0;
      go(2);
      `CHK("awake input", 8'hFF, pad_input_en)
      $display("input enable test done");
      end_of_test;
   end
endmodule // tb
